// *** rtl/rcc_ctrl.sv ***
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// How it works
// - Auto enabled: direction input picks raise/lower
// - Manual mode overrides auto; follows push inputs
// - Both manual pushes: both outputs off
// - Safety stop forces outputs off, top priority
// - Lower feedback blocks raise, error 1
// - Raise feedback blocks lower, error 2
// - Feedback inputs ignored unless enabled
// - Minimum on-time (unless safety stop or a feedback block cuts the pulse) and dead time enforced
// - Status byte encodes current activity
module rcc_ctrl
    import rcc_pkg::*;
(
    input wire logic mclk, // Clock, 125 MHz
    input wire logic srst, // Sync reset, active high
    input wire logic direction_select, // Auto direction, high raises
    input wire logic manual_raise, // Manual raise push
    input wire logic manual_lower, // Manual lower push
    input wire logic safety_stop, // Forces outputs off
    input wire logic raise_fb, // Raise relay feedback
    input wire logic lower_fb, // Lower relay feedback
    output logic raise_out, // Raise contactor drive
    output logic lower_out, // Lower contactor drive
    output logic [7:0] status, // Activity and error code
    output logic irq, // Level interrupt
    input wire logic [7:0] s_axi_awaddr, // AXI write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);
    logic [RCC_CTRL_W-1:0] ctrl_q;
    logic [31:0] ton_q;
    logic [31:0] dead_time_q;
    logic [RCC_IRQ_W-1:0] ist_q;
    logic [RCC_IRQ_W-1:0] imask_q;
    logic [7:0] status_q;
    logic raise_q;
    logic lower_q;
    logic irq_q;
    rcc_state_type st_q;
    rcc_dir_type req;
    logic auto_en;
    logic man_en;
    logic fb_en;
    logic block_up;
    logic block_dn;
    logic tmr_load;
    logic [31:0] tmr_count;
    logic tmr_done;
    logic [RCC_IRQ_W-1:0] ev;
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_go;
    logic [31:0] wmask;

    // ****************************************
    // Mode selection
    // ****************************************
    assign auto_en = ctrl_q[RCC_CTRL_AUTO_BIT];
    assign man_en = ctrl_q[RCC_CTRL_MANUAL_BIT];
    assign fb_en = ctrl_q[RCC_CTRL_FB_BIT];
    assign block_up = fb_en && lower_fb;
    assign block_dn = fb_en && raise_fb;

    // Requested direction before timing is applied
    always_comb begin
        req = '0;
        if (safety_stop) begin
            req = '0;
        end else if (man_en) begin
            if (manual_raise && !manual_lower) begin
                req.raise = 1'b1;
            end else if (manual_lower && !manual_raise) begin
                req.lower = 1'b1;
            end
        end else if (auto_en) begin
            req.raise = direction_select;
            req.lower = !direction_select;
        end
        // Feedback veto applies last so a stuck relay blocks any mode
        if (block_up) begin
            req.raise = 1'b0;
        end
        if (block_dn) begin
            req.lower = 1'b0;
        end
    end

    // ****************************************
    // Drive sequencer
    // ****************************************
    rcc_timer #(.W(32)) u_timer (
        .mclk(mclk),
        .srst(srst),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // Timer loads min on-time at pulse start and dead time at pulse end
    always_comb begin
        tmr_load = 1'b0;
        tmr_count = ton_q;
        case (st_q)
            RCC_IDLE: begin
                if (req.raise || req.lower) begin
                    tmr_load = 1'b1;
                end
            end
            RCC_RAISE, RCC_LOWER: begin
                // Same exit test as the sequencer, so a feedback cut also gets a full dead time
                if (safety_stop || (st_q == RCC_RAISE ? block_up || (!req.raise && tmr_done)
                        : block_dn || (!req.lower && tmr_done))) begin
                    tmr_load = 1'b1;
                    tmr_count = dead_time_q;
                end
            end
            default: begin
            end
        endcase
    end

    // Safety stop or a feedback block cuts a pulse short; otherwise on-time is honoured
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q <= RCC_IDLE;
            raise_q <= 1'b0;
            lower_q <= 1'b0;
        end else begin
            case (st_q)
                RCC_IDLE: begin
                    if (req.raise) begin
                        st_q <= RCC_RAISE;
                        raise_q <= 1'b1;
                    end else if (req.lower) begin
                        st_q <= RCC_LOWER;
                        lower_q <= 1'b1;
                    end
                end
                RCC_RAISE: begin
                    if (safety_stop || block_up || (!req.raise && tmr_done)) begin
                        st_q <= RCC_DEAD;
                        raise_q <= 1'b0;
                    end
                end
                RCC_LOWER: begin
                    if (safety_stop || block_dn || (!req.lower && tmr_done)) begin
                        st_q <= RCC_DEAD;
                        lower_q <= 1'b0;
                    end
                end
                default: begin
                    if (tmr_done) begin
                        st_q <= RCC_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Status byte
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            status_q <= RCC_ST_AUTO_OFF;
        end else if (safety_stop) begin
            status_q <= RCC_ST_SAFE;
        end else if (block_up && (man_en ? manual_raise && !manual_lower
                                         : auto_en && direction_select)) begin
            status_q <= RCC_ST_ERR_UP;
        end else if (block_dn && (man_en ? manual_lower && !manual_raise
                                         : auto_en && !direction_select)) begin
            status_q <= RCC_ST_ERR_DN;
        end else if (man_en) begin
            status_q <= req.raise ? RCC_ST_MAN_UP :
                        req.lower ? RCC_ST_MAN_DN : RCC_ST_MAN_IDLE;
        end else if (auto_en) begin
            status_q <= direction_select ? RCC_ST_AUTO_UP : RCC_ST_AUTO_DN;
        end else begin
            status_q <= RCC_ST_AUTO_OFF;
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    assign ev[0] = status_q != RCC_ST_ERR_UP && block_up && req == '0 && !safety_stop
                   && (man_en ? manual_raise && !manual_lower : auto_en && direction_select);
    assign ev[1] = status_q != RCC_ST_ERR_DN && block_dn && !safety_stop
                   && (man_en ? manual_lower && !manual_raise : auto_en && !direction_select);
    assign ev[2] = safety_stop && status_q != RCC_ST_SAFE;
    assign ev[3] = st_q == RCC_IDLE && (req.raise || req.lower);

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            ist_q <= '0;
        end else begin
            ist_q <= (ist_q & ~((wr_go && awaddr_q == RCC_IRQ_STAT_OFS && wstrb_q[0])
                                 ? wdata_q[RCC_IRQ_W-1:0] : '0)) | ev;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(ist_q & imask_q);
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    // Address and data captured independently, in either order
    always_ff @(posedge mclk) begin
        if (srst) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (s_axi_awvalid && !aw_hold_q) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && !w_hold_q) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // Register writes and write response
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_q <= RCC_CTRL_RST;
            ton_q <= RCC_TON_RST;
            dead_time_q <= RCC_DEAD_TIME_RST;
            imask_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
        end else begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= 2'h0;
                if (awaddr_q == RCC_CTRL_OFS) begin
                    if (wstrb_q[0]) ctrl_q <= wdata_q[RCC_CTRL_W-1:0];
                end else if (awaddr_q == RCC_TON_OFS) begin
                    ton_q <= (ton_q & ~wmask) | (wdata_q & wmask);
                end else if (awaddr_q == RCC_DEAD_TIME_OFS) begin
                    dead_time_q <= (dead_time_q & ~wmask) | (wdata_q & wmask);
                end else if (awaddr_q == RCC_IRQ_MASK_OFS) begin
                    if (wstrb_q[0]) imask_q <= wdata_q[RCC_IRQ_W-1:0];
                end else if (awaddr_q == RCC_IRQ_STAT_OFS || awaddr_q == RCC_INPUT_OFS
                             || awaddr_q == RCC_STATUS_OFS) begin
                    bresp_q <= 2'h0;
                end else begin
                    bresp_q <= 2'h2; // Unmapped: SLVERR
                end
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read path: one-cycle registered answer
    always_ff @(posedge mclk) begin
        if (srst) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= 2'h0;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= 2'h0;
            rdata_q <= '0;
            if (s_axi_araddr == RCC_CTRL_OFS) begin
                rdata_q <= 32'(ctrl_q);
            end else if (s_axi_araddr == RCC_INPUT_OFS) begin
                rdata_q <= {24'h0, raise_q, lower_q, lower_fb, raise_fb, safety_stop,
                            manual_lower, manual_raise, direction_select};
            end else if (s_axi_araddr == RCC_STATUS_OFS) begin
                rdata_q <= {22'h0, st_q, status_q};
            end else if (s_axi_araddr == RCC_TON_OFS) begin
                rdata_q <= ton_q;
            end else if (s_axi_araddr == RCC_DEAD_TIME_OFS) begin
                rdata_q <= dead_time_q;
            end else if (s_axi_araddr == RCC_IRQ_STAT_OFS) begin
                rdata_q <= 32'(ist_q);
            end else if (s_axi_araddr == RCC_IRQ_MASK_OFS) begin
                rdata_q <= 32'(imask_q);
            end else begin
                rresp_q <= 2'h2;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_hold_q;
    assign s_axi_wready = !w_hold_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign raise_out = raise_q;
    assign lower_out = lower_q;
    assign status = status_q;
    assign irq = irq_q;

    // ****************************************
    // Assertions
    // ****************************************
    property p_excl;
        @(posedge mclk) disable iff (srst) !(raise_q && lower_q);
    endproperty
    a_excl: assert property (p_excl) else $error("raise and lower both on");

    property p_safe;
        @(posedge mclk) disable iff (srst) safety_stop |=> !raise_q && !lower_q;
    endproperty
    a_safe: assert property (p_safe) else $error("outputs on after safety stop");

    property p_safe_st;
        @(posedge mclk) disable iff (srst) safety_stop |=> status_q == RCC_ST_SAFE;
    endproperty
    a_safe_st: assert property (p_safe_st) else $error("status not 101 on stop");

    property p_blk_up;
        @(posedge mclk) disable iff (srst) fb_en && lower_fb && !raise_q |=> !raise_q;
    endproperty
    a_blk_up: assert property (p_blk_up) else $error("raise set despite feedback");

    property p_blk_dn;
        @(posedge mclk) disable iff (srst) fb_en && raise_fb && !lower_q |=> !lower_q;
    endproperty
    a_blk_dn: assert property (p_blk_dn) else $error("lower set despite feedback");

    property p_both_man;
        @(posedge mclk) disable iff (srst)
            man_en && manual_raise && manual_lower && !raise_q && !lower_q
            |=> !raise_q && !lower_q;
    endproperty
    a_both_man: assert property (p_both_man) else $error("output on with both pushes");

    property p_dead;
        @(posedge mclk) disable iff (srst)
            $fell(raise_q) || $fell(lower_q) |-> !raise_q && !lower_q ##1 !raise_q && !lower_q;
    endproperty
    a_dead: assert property (p_dead) else $error("dead time skipped");

    property p_auto_up;
        @(posedge mclk) disable iff (srst)
            !safety_stop && !man_en && auto_en && direction_select && !fb_en
            |=> status_q == RCC_ST_AUTO_UP;
    endproperty
    a_auto_up: assert property (p_auto_up) else $error("auto raise status wrong");

    property p_man_st;
        @(posedge mclk) disable iff (srst)
            !safety_stop && man_en && !manual_raise && !manual_lower
            |=> status_q == RCC_ST_MAN_IDLE;
    endproperty
    a_man_st: assert property (p_man_st) else $error("manual idle status wrong");

    c_raise: cover property (@(posedge mclk) disable iff (srst) $rose(raise_q));
    c_lower: cover property (@(posedge mclk) disable iff (srst) $rose(lower_q));
    c_stop: cover property (@(posedge mclk) disable iff (srst) raise_q ##1 safety_stop);
    c_err: cover property (@(posedge mclk) disable iff (srst) status_q == RCC_ST_ERR_UP);
endmodule : rcc_ctrl

// *** rtl/rcc_pkg.sv ***
package rcc_pkg;

    // ****************************************
    // Register map (AXI4-Lite byte addresses)
    // ****************************************
    localparam logic [7:0] RCC_CTRL_OFS = 8'h00;
    localparam logic [7:0] RCC_INPUT_OFS = 8'h04;
    localparam logic [7:0] RCC_STATUS_OFS = 8'h08;
    localparam logic [7:0] RCC_TON_OFS = 8'h0c;
    localparam logic [7:0] RCC_DEAD_TIME_OFS = 8'h10;
    localparam logic [7:0] RCC_IRQ_STAT_OFS = 8'h14;
    localparam logic [7:0] RCC_IRQ_MASK_OFS = 8'h18;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int RCC_CTRL_AUTO_BIT = 0;
    localparam int RCC_CTRL_MANUAL_BIT = 1;
    localparam int RCC_CTRL_FB_BIT = 2;
    localparam int RCC_CTRL_W = 3;
    localparam logic [2:0] RCC_CTRL_RST = 3'h0;

    // ****************************************
    // Timing defaults, in microseconds
    // ****************************************
    localparam int RCC_CLK_MHZ = 125;
    localparam int RCC_TON_US_DFLT = 1;
    localparam int RCC_DEAD_TIME_US_DFLT = 1;
    localparam logic [31:0] RCC_TON_RST = 32'(RCC_TON_US_DFLT * RCC_CLK_MHZ);
    localparam logic [31:0] RCC_DEAD_TIME_RST = 32'(RCC_DEAD_TIME_US_DFLT * RCC_CLK_MHZ);

    // ****************************************
    // Status codes
    // ****************************************
    localparam logic [7:0] RCC_ST_ERR_UP = 8'h01;
    localparam logic [7:0] RCC_ST_ERR_DN = 8'h02;
    localparam logic [7:0] RCC_ST_SAFE = 8'h65;
    localparam logic [7:0] RCC_ST_MAN_IDLE = 8'h66;
    localparam logic [7:0] RCC_ST_MAN_UP = 8'h67;
    localparam logic [7:0] RCC_ST_MAN_DN = 8'h68;
    localparam logic [7:0] RCC_ST_AUTO_OFF = 8'h6e;
    localparam logic [7:0] RCC_ST_AUTO_UP = 8'h6f;
    localparam logic [7:0] RCC_ST_AUTO_DN = 8'h70;

    // Interrupt bits: 0 error up, 1 error down, 2 safety stop, 3 pulse start
    localparam int RCC_IRQ_W = 4;

    // Requested direction from the mode logic
    typedef struct packed {
        logic raise;
        logic lower;
    } rcc_dir_type;

    typedef enum logic [1:0] {
        RCC_IDLE,
        RCC_RAISE,
        RCC_LOWER,
        RCC_DEAD
    } rcc_state_type;

endpackage : rcc_pkg

// *** rtl/rcc_timer.sv ***
`timescale 1ns/1ps
// Down counter: loaded with a count, done when it reaches zero
module rcc_timer
    import rcc_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic mclk, // Clock
    input wire logic srst, // Sync reset
    input wire logic load, // Load pulse
    input wire logic [W-1:0] count, // Cycles to run
    output logic done // Count reached zero
);
    logic [W-1:0] cnt_q;

    // Count down, holding at zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign done = (cnt_q == '0);
endmodule : rcc_timer

// *** test/rcc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module rcc_ctrl_tb_top import rcc_pkg::*;;
    // Short timings keep each settle wait small
    localparam int MIN_DRIVE_TIME = 3;
    localparam int DEAD_TIME = 3;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic direction_select = 1'b0;
    logic manual_raise = 1'b0;
    logic manual_lower = 1'b0;
    logic safety_stop = 1'b0;
    logic stuck_raise = 1'b0;
    logic stuck_lower = 1'b0;
    logic raise_fb, lower_fb, raise_out, lower_out, irq;
    logic [7:0] status;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd, r;
    logic [2:0] ctrl_q = 3'h0;
    int fail_count = 0;
    int samples_checked = 0;
    int len, gap;
    logic cut, act_q, raise_p, lower_p;

    rcc_ctrl dut (.mclk, .srst, .direction_select, .manual_raise, .manual_lower, .safety_stop,
        .raise_fb, .lower_fb, .raise_out, .lower_out, .status, .irq, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    rcc_relay_model relays (.mclk, .raise_out, .lower_out, .stuck_raise, .stuck_lower,
        .raise_fb, .lower_fb);

    // Free-running 125 MHz clock
    initial begin
        forever #4 mclk = ~mclk;
    end

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    // Address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        check("axi_write_done", n < 200, 1);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
        int n;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge mclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                e = s_axi_rresp;
                break;
            end
        end
        s_axi_rready <= 1'b0;
        check("axi_read_done", n < 200, 1);
    endtask : axi_read

    // Reference model: wait out on-time and dead time, then compare drives and status
    task automatic settle_check();
        int up = 0;
        int dn = 0;
        int st;
        logic fb;
        // Inputs were just changed by non-blocking assignment; read them once they have landed
        repeat (MIN_DRIVE_TIME + DEAD_TIME + 8) @(posedge mclk);
        fb = ctrl_q[RCC_CTRL_FB_BIT];
        if (!safety_stop && ctrl_q[RCC_CTRL_MANUAL_BIT]) begin
            up = manual_raise & !manual_lower;
            dn = manual_lower & !manual_raise;
        end else if (!safety_stop && ctrl_q[RCC_CTRL_AUTO_BIT]) begin
            up = direction_select;
            dn = !direction_select;
        end
        if (safety_stop) st = RCC_ST_SAFE;
        else if (up && fb && stuck_lower) st = RCC_ST_ERR_UP;
        else if (dn && fb && stuck_raise) st = RCC_ST_ERR_DN;
        else if (ctrl_q[RCC_CTRL_MANUAL_BIT]) st = up ? RCC_ST_MAN_UP : dn ? RCC_ST_MAN_DN : RCC_ST_MAN_IDLE;
        else if (ctrl_q[RCC_CTRL_AUTO_BIT]) st = up ? RCC_ST_AUTO_UP : RCC_ST_AUTO_DN;
        else st = RCC_ST_AUTO_OFF;
        check("raise_out", raise_out, up && !(fb && stuck_lower));
        check("lower_out", lower_out, dn && !(fb && stuck_raise));
        check("status", status, st);
        axi_read(RCC_STATUS_OFS, rd, rs);
        check("status_reg", rd[7:0], st);
    endtask : settle_check

    // ****************************************
    // Pulse monitor
    // ****************************************
    // Pulses seen with safety stop or feedback enabled are exempt from the on-time check
    always @(posedge mclk) begin
        if (srst) begin
            len = 0;
            gap = 1000;
            cut = 1'b0;
            act_q = 1'b0;
        end else begin
            check("overlap", raise_out & lower_out, 1'b0);
            if ((raise_out & !raise_p) | (lower_out & !lower_p)) check("dead", gap >= DEAD_TIME, 1);
            if (raise_out | lower_out) begin
                len++;
                gap = 0;
                if (safety_stop | ctrl_q[RCC_CTRL_FB_BIT]) cut = 1'b1;
            end else if (act_q) begin
                if (!cut) check("on_time", len >= MIN_DRIVE_TIME, 1);
                len = 0;
                cut = 1'b0;
                gap = 1;
            end else begin
                gap++;
            end
            act_q = raise_out | lower_out;
        end
        raise_p = raise_out;
        lower_p = lower_out;
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        stop_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hf2b19b0d));
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        check("status_rst", status, RCC_ST_AUTO_OFF);
        check("drives_rst", {raise_out, lower_out}, 2'b00);
        axi_read(RCC_TON_OFS, rd, rs);
        check("ton_rst", rd, RCC_TON_RST);
        axi_read(8'h1c, rd, rs);
        check("unmapped_resp", rs, 2'b10);
        check("unmapped_data", rd, 32'h0);
        axi_write(RCC_TON_OFS, MIN_DRIVE_TIME);
        axi_write(RCC_DEAD_TIME_OFS, DEAD_TIME);
        axi_read(RCC_DEAD_TIME_OFS, rd, rs);
        check("dead_time", rd, DEAD_TIME);
        $display("test reset_and_map done");
        // Random modes, pushes, safety and welded contacts
        for (int i = 0; i < 80; i++) begin
            r = $urandom;
            ctrl_q = r[2:0];
            axi_write(RCC_CTRL_OFS, {29'h0, r[2:0]});
            @(posedge mclk);
            direction_select <= r[3];
            manual_raise <= r[4];
            manual_lower <= r[5];
            safety_stop <= (r[8:6] == 3'h0);
            stuck_raise <= (r[10:9] == 2'h0);
            stuck_lower <= (r[12:11] == 2'h0);
            settle_check();
        end
        $display("test random_modes done");
        // Interrupt: raise while masked, unmask, clear
        @(posedge mclk);
        safety_stop <= 1'b0;
        axi_write(RCC_IRQ_MASK_OFS, 32'h0);
        axi_write(RCC_IRQ_STAT_OFS, 32'hf);
        @(posedge mclk);
        safety_stop <= 1'b1;
        repeat (4) @(posedge mclk);
        check("irq_masked", irq, 1'b0);
        axi_read(RCC_IRQ_STAT_OFS, rd, rs);
        check("irq_stat", rd[2], 1'b1);
        axi_write(RCC_IRQ_MASK_OFS, 32'h4);
        repeat (3) @(posedge mclk);
        check("irq_on", irq, 1'b1);
        safety_stop <= 1'b0;
        axi_write(RCC_IRQ_STAT_OFS, 32'h4);
        repeat (3) @(posedge mclk);
        check("irq_clr", irq, 1'b0);
        $display("test irq done");
        stop_test();
    end
endmodule : rcc_ctrl_tb_top

// *** test/rcc_relay_model.sv ***
`timescale 1ns/1ps
// Relay pair behind the contactor drives; a contact reports closed one cycle after its coil
module rcc_relay_model (
    input wire logic mclk, // Clock
    input wire logic raise_out, // Raise coil drive
    input wire logic lower_out, // Lower coil drive
    input wire logic stuck_raise, // Raise contact welded shut
    input wire logic stuck_lower, // Lower contact welded shut
    output logic raise_fb, // Raise contact state
    output logic lower_fb // Lower contact state
);
    logic raise_q = 1'b0;
    logic lower_q = 1'b0;

    // Contacts lag the coil, so a fast reversal can meet a contact that is still closed
    always_ff @(posedge mclk) begin
        raise_q <= raise_out;
        lower_q <= lower_out;
    end

    // A welded contact reads closed whatever the coil does
    assign raise_fb = raise_q | stuck_raise;
    assign lower_fb = lower_q | stuck_lower;
endmodule : rcc_relay_model
